/* File: include/ofd_pkg.sv */
// package for the operand field decoder: offsets, layouts, codes, carriers
package ofd_pkg;

  // ********************************************
  // register map (byte addresses)
  // ********************************************
  localparam logic [7:0] OFD_CTRL_OFS = 8'h00;
  localparam logic [7:0] OFD_INSN_OFS = 8'h04;
  localparam logic [7:0] OFD_EA_OFS = 8'h08;
  localparam logic [7:0] OFD_DEC_OFS = 8'h0C;
  localparam logic [7:0] OFD_IMM_OFS = 8'h10;
  localparam logic [7:0] OFD_BR_OFS = 8'h14;
  localparam logic [7:0] OFD_REGW_OFS = 8'h18;
  localparam logic [7:0] OFD_REGD_OFS = 8'h1C;
  localparam logic [7:0] OFD_RDBK_OFS = 8'h20;
  localparam logic [7:0] OFD_FLAG_OFS = 8'h24;
  localparam logic [7:0] OFD_XLAT_OFS = 8'h28;
  localparam logic [7:0] OFD_STR_OFS = 8'h2C;
  localparam logic [7:0] OFD_SREL_OFS = 8'h30;

  // ********************************************
  // field positions and codes
  // ********************************************
  localparam int OFD_W_BIT = 0;
  localparam int OFD_S_BIT = 1;
  localparam logic [1:0] OFD_DISP_NONE = 2'h0;
  localparam logic [1:0] OFD_DISP_8 = 2'h1;
  localparam logic [1:0] OFD_DISP_16 = 2'h2;
  localparam logic [1:0] OFD_REG_DIRECT = 2'h3;
  localparam logic [2:0] OFD_LOC_DIRECT = 3'h6;
  localparam logic [1:0] OFD_RESP_OKAY = 2'h0;
  localparam logic [1:0] OFD_RESP_SLVERR = 2'h2;
  localparam logic [15:0] OFD_REG_RST = 16'h0000;
  localparam logic [15:0] OFD_FLAG_RST = 16'h0000;

  typedef enum logic [3:0] {
    OFD_SEG_STACK,
    OFD_SEG_PROG,
    OFD_SEG_DATA0,
    OFD_SEG_DATA1
  } ofd_seg_t;

  // flag-update classes
  typedef enum logic [2:0] {
    OFD_FL_KEEP,
    OFD_FL_CLEAR,
    OFD_FL_SET,
    OFD_FL_RESULT,
    OFD_FL_UNDEF,
    OFD_FL_RESTORE
  } ofd_flcls_t;

  // decoded instruction fields
  typedef struct packed {
    logic [7:0] coproc_opcode;
    logic [1:0] seg_sel;
    logic [1:0] mod_field;
    logic [2:0] gp_operand_selector;
    logic [2:0] src_selector;
    logic [2:0] loc_field;
    logic sign_ext;
    logic word_sel;
  } ofd_insn_t;

  // decode result
  typedef struct packed {
    logic [15:0] ea;
    logic [3:0] dst_reg;
    logic [3:0] src_reg;
    logic [1:0] seg;
    logic reg_direct;
    logic direct_addr;
  } ofd_dec_t;

endpackage

/* File: rtl/ofd_decoder.sv */
// operand field decoder with register file and axi4-lite slave
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// RULE_01 - size bit: 0 byte, 1 word operands
// RULE_02 - s and w set: sign-extend immediate byte
// RULE_03 - disp field: 00 none, 01 8-bit, 10 16-bit
// RULE_04 - location 000-011: base plus index sums
// RULE_05 - location 100,101,111: single register base
// RULE_06 - location 110 with 00: direct address
// RULE_07 - 8-bit displacement sign-extended before add
// RULE_08 - byte register selection order
// RULE_09 - word register selection, second source field
// RULE_10 - segment codes 00,01,10 mapping
// RULE_11 - segment code 11 selects data segment zero
// RULE_12 - disp field 11 means register direct
// RULE_13 - immediate ranges for 3/4/8/16-bit constants
// RULE_14 - short branch: next address plus signed byte
// RULE_15 - translate table is 256 bytes, byte index
// RULE_16 - strings: source via source_index, dest via dest_index
// RULE_17 - return discard count 0 to 64K bytes
// RULE_18 - coprocessor opcode bits passed out
// RULE_19 - six flag update classes per flag
// RULE_20 - all architectural registers are 16 bits
// RULE_21 - accumulator usable as word or byte halves
module ofd_decoder
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] coproc_opcode,
  output logic coproc_valid
);
  import ofd_pkg::*;

  // ********************************************
  // register file: 8 general, 4 segment
  // ********************************************
  logic [15:0] gpr_ff [0:7]; // [RULE_20]
  logic [15:0] seg_ff [0:3];
  logic [15:0] flag_word_ff;
  logic [15:0] flag_saved_ff;
  ofd_insn_t insn_ff;
  logic [15:0] disp_ff;
  logic [15:0] imm_ff;
  logic [15:0] pc_next_ff;
  logic [15:0] srel_ff;
  logic [3:0] imm_kind_ff;
  logic [7:0] xlat_idx_ff;
  logic [3:0] wr_idx_ff;
  logic [15:0] ea_ff;
  logic [15:0] imm_out_ff;
  logic [15:0] br_ff;
  logic [15:0] rdbk_ff;
  ofd_dec_t dec_ff;
  // ********************************************
  // axi write path
  // ********************************************
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;
  logic wr_hit;

  assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (do_write)
      aw_hold_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (do_write)
      w_hold_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_hold_ff && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_comb
  begin
    case (awaddr_ff)
      OFD_CTRL_OFS, OFD_INSN_OFS, OFD_IMM_OFS, OFD_BR_OFS, OFD_REGW_OFS,
      OFD_REGD_OFS, OFD_FLAG_OFS, OFD_XLAT_OFS, OFD_SREL_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OFD_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? OFD_RESP_OKAY : OFD_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ********************************************
  // software writes into the operand state
  // ********************************************
  logic wr_on;
  assign wr_on = do_write && wr_hit;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      insn_ff <= '0;
      disp_ff <= 16'h0000;
      imm_ff <= 16'h0000;
      imm_kind_ff <= 4'h0;
      pc_next_ff <= 16'h0000;
      xlat_idx_ff <= 8'h00;
      srel_ff <= 16'h0000;
      wr_idx_ff <= 4'h0;
    end
    else if (wr_on)
    begin
      case (awaddr_ff)
        OFD_CTRL_OFS: wr_idx_ff <= wdata_ff[3:0];
        OFD_INSN_OFS: insn_ff <= wdata_ff[$bits(ofd_insn_t)-1:0];
        OFD_IMM_OFS:
        begin
          imm_ff <= wdata_ff[15:0];
          imm_kind_ff <= wdata_ff[19:16];
          disp_ff <= wdata_ff[15:0];
        end
        OFD_BR_OFS: pc_next_ff <= wdata_ff[15:0];
        OFD_XLAT_OFS: xlat_idx_ff <= wdata_ff[7:0]; // [RULE_15]
        OFD_SREL_OFS: srel_ff <= wdata_ff[15:0]; // [RULE_17]
        default: ;
      endcase
    end
  end

  // ********************************************
  // effective address formation
  // ********************************************
  logic [15:0] base;
  logic [15:0] disp_ext;
  logic [15:0] ea;
  logic direct_addr;
  logic reg_direct;
  always_comb
  begin
    direct_addr = 1'b0;
    reg_direct = (insn_ff.mod_field == OFD_REG_DIRECT); // [RULE_12]
    case (insn_ff.loc_field)
      3'h0: base = gpr_ff[3] + gpr_ff[6]; // [RULE_04]
      3'h1: base = gpr_ff[3] + gpr_ff[7]; // [RULE_04]
      3'h2: base = gpr_ff[5] + gpr_ff[6]; // [RULE_04]
      3'h3: base = gpr_ff[5] + gpr_ff[7]; // [RULE_04]
      3'h4: base = gpr_ff[6]; // [RULE_05] [RULE_16]
      3'h5: base = gpr_ff[7]; // [RULE_05] [RULE_16]
      3'h6: base = gpr_ff[5];
      default: base = gpr_ff[3]; // [RULE_05]
    endcase
    case (insn_ff.mod_field)
      OFD_DISP_8: disp_ext = {{8{disp_ff[7]}}, disp_ff[7:0]}; // [RULE_03] [RULE_07]
      OFD_DISP_16: disp_ext = disp_ff; // [RULE_03]
      default: disp_ext = 16'h0000; // [RULE_03]
    endcase
    if (insn_ff.loc_field == OFD_LOC_DIRECT && insn_ff.mod_field == OFD_DISP_NONE)
    begin
      direct_addr = 1'b1;
      ea = disp_ff; // [RULE_06]
    end
    else
      ea = base + disp_ext; // [RULE_06]
  end

  // ********************************************
  // register, segment and immediate decode
  // ********************************************
  logic [15:0] imm_val;
  always_comb
  begin
    if (insn_ff.word_sel && insn_ff.sign_ext)
      imm_val = {{8{imm_ff[7]}}, imm_ff[7:0]}; // [RULE_02]
    else if (insn_ff.word_sel)
      imm_val = imm_ff; // [RULE_01]
    else
      imm_val = {8'h00, imm_ff[7:0]}; // [RULE_01]
    case (imm_kind_ff)
      4'h3: imm_val = {13'h0000, imm_ff[2:0]}; // [RULE_13]
      4'h4: imm_val = {12'h000, imm_ff[3:0]}; // [RULE_13]
      4'h8: imm_val = {8'h00, imm_ff[7:0]}; // [RULE_13]
      default: ;
    endcase
  end

  // map 3-bit code to 4-bit target: bit3 marks byte, bit2 high half
  function automatic logic [3:0] reg_code(input logic [2:0] sel, input logic wsel);
    reg_code = wsel ? {1'b0, sel} : {1'b1, sel}; // [RULE_08] [RULE_09]
  endfunction

  // read one register as byte or word view
  function automatic logic [15:0] reg_view(input logic [3:0] code, input logic [15:0] r [0:7]);
    logic [15:0] w;
    w = r[{1'b0, code[1:0]}];
    if (!code[3])
      reg_view = r[code[2:0]];
    else if (code[2])
      reg_view = {8'h00, w[15:8]}; // [RULE_21]
    else
      reg_view = {8'h00, w[7:0]}; // [RULE_21]
  endfunction

  logic [1:0] seg_dec;
  always_comb
  begin
    case (insn_ff.seg_sel)
      2'h0: seg_dec = 2'(OFD_SEG_DATA1); // [RULE_10]
      2'h1: seg_dec = 2'(OFD_SEG_PROG); // [RULE_10]
      2'h2: seg_dec = 2'(OFD_SEG_STACK); // [RULE_10]
      default: seg_dec = 2'(OFD_SEG_DATA0); // [RULE_11]
    endcase
  end

  // ********************************************
  // registered results
  // ********************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ea_ff <= 16'h0000;
      imm_out_ff <= 16'h0000;
      br_ff <= 16'h0000;
      dec_ff <= '0;
      rdbk_ff <= 16'h0000;
    end
    else
    begin
      ea_ff <= ea;
      imm_out_ff <= imm_val;
      br_ff <= pc_next_ff + {{8{imm_ff[7]}}, imm_ff[7:0]}; // [RULE_14]
      dec_ff.ea <= ea;
      dec_ff.dst_reg <= reg_code(insn_ff.gp_operand_selector, insn_ff.word_sel);
      dec_ff.src_reg <= reg_code(insn_ff.src_selector, insn_ff.word_sel); // [RULE_09]
      dec_ff.seg <= seg_dec;
      dec_ff.reg_direct <= reg_direct;
      dec_ff.direct_addr <= direct_addr;
      rdbk_ff <= reg_view(reg_code(insn_ff.gp_operand_selector, insn_ff.word_sel), gpr_ff);
    end
  end

  // ********************************************
  // register write-back and flags
  // ********************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 8; i++)
        gpr_ff[i] <= OFD_REG_RST;
      for (int i = 0; i < 4; i++)
        seg_ff[i] <= OFD_REG_RST;
    end
    else if (wr_on && awaddr_ff == OFD_REGW_OFS)
    begin
      if (wr_idx_ff[3])
        seg_ff[wr_idx_ff[1:0]] <= wdata_ff[15:0];
      else if (insn_ff.word_sel)
        gpr_ff[wr_idx_ff[2:0]] <= wdata_ff[15:0]; // [RULE_01]
      else if (wr_idx_ff[2])
        gpr_ff[{1'b0, wr_idx_ff[1:0]}][15:8] <= wdata_ff[7:0]; // [RULE_21]
      else
        gpr_ff[{1'b0, wr_idx_ff[1:0]}][7:0] <= wdata_ff[7:0]; // [RULE_21]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_word_ff <= OFD_FLAG_RST;
      flag_saved_ff <= OFD_FLAG_RST;
    end
    else if (wr_on && awaddr_ff == OFD_FLAG_OFS)
    begin
      flag_saved_ff <= flag_word_ff;
      // class and bit travel with this write; a stored copy would lag one write
      case (wdata_ff[2:0])
        3'(OFD_FL_CLEAR): flag_word_ff[wdata_ff[7:4]] <= 1'b0; // [RULE_19]
        3'(OFD_FL_SET): flag_word_ff[wdata_ff[7:4]] <= 1'b1; // [RULE_19]
        3'(OFD_FL_RESULT): flag_word_ff[wdata_ff[7:4]] <= wdata_ff[16]; // [RULE_19]
        3'(OFD_FL_UNDEF): flag_word_ff[wdata_ff[7:4]] <= 1'b0; // [RULE_19]
        3'(OFD_FL_RESTORE): flag_word_ff <= flag_saved_ff; // [RULE_19]
        default: ; // [RULE_19]
      endcase
    end
  end

  // coprocessor escape opcode handed out as a one-cycle pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      coproc_opcode <= 8'h00;
      coproc_valid <= 1'b0;
    end
    else
    begin
      coproc_valid <= wr_on && awaddr_ff == OFD_INSN_OFS;
      if (wr_on && awaddr_ff == OFD_INSN_OFS)
        coproc_opcode <= wdata_ff[$bits(ofd_insn_t)-1 -: 8]; // [RULE_18]
    end
  end

  // ********************************************
  // axi read path
  // ********************************************
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFD_CTRL_OFS: rd_mux = {28'h0000000, wr_idx_ff};
      OFD_INSN_OFS: rd_mux = 32'($unsigned(insn_ff));
      OFD_EA_OFS: rd_mux = {16'h0000, ea_ff};
      OFD_DEC_OFS: rd_mux = 32'($unsigned(dec_ff));
      OFD_IMM_OFS: rd_mux = {16'h0000, imm_out_ff};
      OFD_BR_OFS: rd_mux = {16'h0000, br_ff};
      OFD_RDBK_OFS: rd_mux = {16'h0000, rdbk_ff};
      OFD_FLAG_OFS: rd_mux = {flag_saved_ff, flag_word_ff};
      OFD_XLAT_OFS: rd_mux = {16'h0000, gpr_ff[3] + {8'h00, xlat_idx_ff}}; // [RULE_15]
      OFD_STR_OFS: rd_mux = {gpr_ff[7], gpr_ff[6]}; // [RULE_16]
      OFD_SREL_OFS: rd_mux = {16'h0000, srel_ff};
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= OFD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? OFD_RESP_OKAY : OFD_RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
    else
      s_axi_arready <= 1'b1;
  end

endmodule // ofd_decoder

/* File: verification/ofd_monitor.sv */
// concurrent checks on the operand field decoder ports
`timescale 1ns/100ps
module ofd_mon
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] coproc_opcode,
  input wire logic coproc_valid
);
  import ofd_pkg::*;
  logic [7:0] op_ff;
  // ****
  // last code seen on the write data channel
  // ****
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      op_ff <= 8'h00;
    else if (s_axi_wvalid && s_axi_wready)
      op_ff <= s_axi_wdata[22:15];
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFD_SREL_OFS
    |=> s_axi_rresp == OFD_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read error");
  wr_unmapped_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > OFD_SREL_OFS
    |-> ##[1:3] s_axi_bvalid && s_axi_bresp == OFD_RESP_SLVERR) else $error("bad write error");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  cop_pulse_a: assert property (coproc_valid |=> !coproc_valid)
    else $error("code strobe too long");
  cop_value_a: assert property (coproc_valid |-> coproc_opcode == op_ff)
    else $error("wrong code");
  cop_after_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_awaddr == OFD_INSN_OFS |-> ##[1:4] coproc_valid) else $error("no code strobe");
endmodule // ofd_mon

/* File: verification/ofd_exec_model.sv */
// execution unit model that collects coprocessor codes
`timescale 1ns/100ps
module ofd_exec_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] coproc_opcode,
  input wire logic coproc_valid,
  output logic [7:0] last_op_ff,
  output logic [7:0] n_ops_ff
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_op_ff <= 8'h00;
      n_ops_ff <= 8'h00;
    end
    else if (coproc_valid)
    begin
      last_op_ff <= coproc_opcode;
      n_ops_ff <= n_ops_ff + 8'h01;
    end
  end
endmodule // ofd_exec_model

/* File: verification/ofd_decoder_tb.sv */
// self-checking bench for the operand field decoder
`timescale 1ns/100ps
module ofd_decoder_tb;
  import ofd_pkg::*;
  localparam logic [15:0] DV = 16'h0080;
  logic aclk;
  logic aresetn = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, r_d, d;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic aw_r, w_r, b_v, ar_r, r_v, cop_v;
  logic [1:0] b_p, r_p, rsp;
  logic [7:0] cop, m_op, m_n;
  logic [15:0] rv [8] = '{16'hA55A, 16'hC31C, 16'h7E81, 16'h1000, 16'hFFFE, 16'h3000,
    16'h0200, 16'h0040};
  logic [1:0] sgt [4] = '{2'(OFD_SEG_DATA1), 2'(OFD_SEG_PROG), 2'(OFD_SEG_STACK),
    2'(OFD_SEG_DATA0)};
  // expected bit 4, data bit, class
  logic [4:0] ft [6] = '{5'h12, 5'h01, 5'h1B, 5'h10, 5'h04, 5'h15};
  int kt [3] = '{3, 4, 8};
  int n_errors = 0;
  int n_tests = 0;
  ofd_insn_t ins;
  // wstrb is ignored by the design, so it stays at full word
  ofd_decoder uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_p), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
    .s_axi_rresp(r_p), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .coproc_opcode(cop),
    .coproc_valid(cop_v));
  ofd_exec_model pm (.aclk(aclk), .aresetn(aresetn), .coproc_opcode(cop),
    .coproc_valid(cop_v), .last_op_ff(m_op), .n_ops_ff(m_n));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ****
  // bus tasks and compares
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    aw_a <= a;
    w_d <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end
    while (b_v !== 1'b1);
    r = b_p;
    b_r <= 1'b0;
    // derived registers settle one cycle after the write
    repeat (2) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (ar_r) ar_v <= 1'b0;
    end
    while (r_v !== 1'b1);
    v = r_d;
    r = r_p;
    r_r <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %0t data %h exp %h", $time, g, e);
    end
  endtask
  task automatic chr(input logic [1:0] g, input logic [1:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %0t resp %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, rsp);
    chr(rsp, OFD_RESP_OKAY);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a, d, rsp);
    chr(rsp, OFD_RESP_OKAY);
    chk(d & m, e & m);
  endtask
  function automatic logic [15:0] ea(input logic [2:0] l, input logic [1:0] m);
    logic [15:0] b;
    case (l)
      3'h0: b = rv[3] + rv[6];
      3'h1: b = rv[3] + rv[7];
      3'h2: b = rv[5] + rv[6];
      3'h3: b = rv[5] + rv[7];
      3'h4: b = rv[6];
      3'h5: b = rv[7];
      3'h6: b = (m == OFD_DISP_NONE) ? 16'h0000 : rv[5];
      default: b = rv[3];
    endcase
    if (m == OFD_DISP_8)
      b = b + {{8{DV[7]}}, DV[7:0]};
    else if (m == OFD_DISP_16 || l == OFD_LOC_DIRECT)
      b = b + DV;
    return b;
  endfunction
  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    $display("mismatch %0t watchdog expired", $time);
    stop_test;
  end
  // ****
  // test sequence
  // ****
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFD_RDBK_OFS, {16'h0, OFD_REG_RST}, 32'hFFFF);
    // word view first, else the loop only fills byte halves
    wrc(OFD_INSN_OFS, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wrc(OFD_CTRL_OFS, 32'(i));
      wrc(OFD_REGW_OFS, {16'h0, rv[i]});
    end
    wrc(OFD_IMM_OFS, {16'h0, DV});
    for (int l = 0; l < 8; l++)
      for (int m = 0; m < 4; m++)
      begin
        ins = '{8'(l * 8 + m), 2'(m), 2'(m), 3'(l), 3'(~l), 3'(l), 1'b0, 1'(l)};
        wrc(OFD_INSN_OFS, {9'h0, ins});
        chk({24'h0, m_op}, {24'h0, ins.coproc_opcode});
        if (m != 3)
          rdc(OFD_EA_OFS, {16'h0, ea(3'(l), 2'(m))}, 32'hFFFF);
        rdc(OFD_DEC_OFS, {20'h0, ~ins.word_sel, ins.gp_operand_selector, ~ins.word_sel,
          ins.src_selector, sgt[m], (m == 3), (l == 6 && m == 0)}, 32'hFFF);
      end
    chk({24'h0, m_n}, 32'd33);
    for (int g = 0; g < 16; g++)
    begin
      ins = '{8'h0, 2'h0, 2'h0, 3'(g), 3'h0, 3'h0, 1'b0, 1'(g >> 3)};
      wrc(OFD_INSN_OFS, {9'h0, ins});
      rdc(OFD_RDBK_OFS, (g > 7) ? {16'h0, rv[g & 7]} : (g[2] ? {24'h0, rv[g & 3][15:8]} :
        {24'h0, rv[g & 3][7:0]}), (g > 7) ? 32'hFFFF : 32'hFF);
    end
    ins = '{8'h0, 2'h0, 2'h0, 3'h0, 3'h0, 3'h0, 1'b1, 1'b1};
    wrc(OFD_INSN_OFS, {9'h0, ins});
    wrc(OFD_IMM_OFS, 32'h0085);
    rdc(OFD_IMM_OFS, 32'hFF85, 32'hFFFF);
    ins.sign_ext = 1'b0;
    wrc(OFD_INSN_OFS, {9'h0, ins});
    rdc(OFD_IMM_OFS, 32'h0085, 32'hFFFF);
    foreach (kt[i])
    begin
      wrc(OFD_IMM_OFS, {12'h0, 4'(kt[i]), 16'hFFFF});
      rdc(OFD_IMM_OFS, 32'((1 << kt[i]) - 1), 32'hFFFF);
    end
    wrc(OFD_IMM_OFS, 32'hFFFF);
    rdc(OFD_IMM_OFS, 32'hFFFF, 32'hFFFF);
    wrc(OFD_BR_OFS, 32'h1000);
    rdc(OFD_BR_OFS, 32'h0FFF, 32'hFFFF);
    wrc(OFD_IMM_OFS, 32'h0080);
    rdc(OFD_BR_OFS, 32'h0F80, 32'hFFFF);
    wrc(OFD_IMM_OFS, 32'h007F);
    rdc(OFD_BR_OFS, 32'h107F, 32'hFFFF);
    wrc(OFD_XLAT_OFS, 32'h01FF);
    rdc(OFD_XLAT_OFS, 32'h10FF, 32'hFFFF);
    rdc(OFD_STR_OFS, {rv[7], rv[6]}, 32'hFFFFFFFF);
    wrc(OFD_SREL_OFS, 32'hFFFE);
    rdc(OFD_SREL_OFS, 32'hFFFE, 32'hFFFF);
    foreach (ft[i])
    begin
      wrc(OFD_FLAG_OFS, {15'h0, ft[i][3], 8'h0, 4'h4, 1'b0, ft[i][2:0]});
      rdc(OFD_FLAG_OFS, {27'h0, ft[i][4], 4'h0}, 32'h10);
    end
    wr(8'h3C, 32'h1, rsp);
    chr(rsp, OFD_RESP_SLVERR);
    rd(8'h3C, d, rsp);
    chr(rsp, OFD_RESP_SLVERR);
    chk(d, 32'h0);
    stop_test;
  end
endmodule // ofd_decoder_tb
bind ofd_decoder ofd_mon mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .coproc_opcode(coproc_opcode), .coproc_valid(coproc_valid));
